// file: hw/se_consts.svh
// constants of the serial eeprom target: address pattern, sizes, timing
// assumes a 25 MHz system clock
`ifndef SE_CONSTS_SVH
`define SE_CONSTS_SVH

// ==========================================================================
// device address and array geometry
`define SE_DEV_PATTERN   4'hA
`define SE_ADDR_W        11
`define SE_PAGE_LOW_W    4
`define SE_PAGE_BYTES    16
`define SE_MEM_BYTES     2048

// ==========================================================================
// timing
`define SE_CLK_NS        40
`define SE_PROG_TIME_NS  5000000
`define SE_PROG_CYCLES   (`SE_PROG_TIME_NS / `SE_CLK_NS)

`endif

// file: hw/se_pkg.sv
// types shared by the serial eeprom target modules
// assumes se_consts.svh for all numeric constants
package se_pkg;

	// ======================================================================
	// bus events seen by the protocol engine
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} se_bus_ev_t;

	// ======================================================================
	// protocol states
	typedef enum logic [2:0] {
		SE_IDLE,
		SE_DEV,
		SE_WADDR,
		SE_WDATA,
		SE_RDATA,
		SE_RACK,
		SE_WAIT
	} se_state_t;

endpackage

// file: hw/se_line_sync.sv
// two-stage synchroniser and edge finder for the serial clock and data pins
// assumes both pins come from outside the clk_i domain
`timescale 1ns/1ns
module se_line_sync
(
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output se_pkg::se_bus_ev_t ev_o
);
	import se_pkg::*;

	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic       scl_q;
	logic       sda_q;

	// ======================================================================
	// synchronisers; the first stage feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			scl_q      <= scl_sync_q[1];
			sda_q      <= sda_sync_q[1];
		end
	end

	// ======================================================================
	// start and stop: data edge while clock stays high
	wire start_w = scl_q & scl_sync_q[1] & sda_q & ~sda_sync_q[1];
	wire stop_w  = scl_q & scl_sync_q[1] & ~sda_q & sda_sync_q[1];
	wire rise_w  = ~scl_q & scl_sync_q[1];
	wire fall_w  = scl_q & ~scl_sync_q[1];

	// one driver for the whole carrier, fields in package order
	assign ev_o = {start_w, stop_w, rise_w, fall_w, sda_sync_q[1]};
endmodule

// file: hw/se_prog_timer.sv
// self-timed programming cycle counter
// assumes start_i is a one-cycle pulse on clk_i
`timescale 1ns/1ns
`include "se_consts.svh"
module se_prog_timer
#(
	parameter int unsigned CYCLES = `SE_PROG_CYCLES
)
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);
	import se_pkg::*;

	logic [22:0] cnt_q;
	logic        busy_q;

	// ======================================================================
	// count from the stop to the end of the program cycle
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			cnt_q  <= 23'h0;
			busy_q <= 1'b0;
		end
		else if (start_i && !busy_q)
		begin
			cnt_q  <= 23'(CYCLES - 1);
			busy_q <= 1'b1;
		end
		else if (busy_q)
		begin
			if (cnt_q == 23'h0)
				busy_q <= 1'b0;
			else
				cnt_q <= cnt_q - 23'h1;
		end
	end

	assign busy_o = busy_q;
	assign done_o = busy_q && (cnt_q == 23'h0);
endmodule

// file: hw/se_eeprom_target.sv
// two-wire serial target of a 2048 x 8 nonvolatile memory
// assumes pins arrive asynchronously; sda is open drain, oe high pulls low
`timescale 1ns/1ns
`include "se_consts.svh"

// Behaviour
// - a device address word follows every start before any operation
// - top four address bits must equal one zero one zero
// - next three bits select the page, upper word address bits
// - eighth bit one means read, zero means write
// - acknowledge on match; on mismatch no acknowledge, back to standby
// - write: word address then data byte, each acknowledged
// - stop after write data starts the timed programming cycle
// - during programming all inputs ignored, no response
// - programming time counts from the stop to cycle end
// - page write takes up to sixteen bytes, each acknowledged
// - only low page bits increment during writes, page stays fixed
// - more than sixteen bytes wrap and overwrite earlier ones
// - polling address acknowledged only after programming ends
// - address counter keeps last address plus one across operations
// - read address wraps from last array byte to first
// - current read sends byte at counter after address acknowledge
// - controller acknowledge continues sequential read, no ack ends it
// - acknowledge driven low during ninth clock of each received word; read words leave it to the controller
// - start and stop are data edges while clock high
module se_eeprom_target
#(
	parameter int unsigned PROG_CYCLES = `SE_PROG_CYCLES,
	parameter int unsigned PAGE_BYTES  = `SE_PAGE_BYTES
)
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	output logic      prog_busy_o
);
	import se_pkg::*;

	localparam int AW = `SE_ADDR_W;
	localparam int PW = `SE_PAGE_LOW_W;

	// ======================================================================
	// storage: the array and the page buffer
	logic [7:0]      mem_q     [0:`SE_MEM_BYTES-1];
	logic [7:0]      pbuf_q    [0:PAGE_BYTES-1];
	logic [PAGE_BYTES-1:0] pvalid_q;
	logic [AW-PW-1:0] prow_q;

	se_bus_ev_t ev;
	se_state_t  st_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic       ack_q;
	logic       ackp_q;
	logic       rd_q;
	logic [AW-1:0] addr_q;
	logic [2:0]    page_q;
	logic [7:0]    out_q;
	logic          drive_q;
	logic          prog_start_q;
	logic          prog_busy;
	logic          prog_done;
	logic [PW:0]   cmt_q;
	logic          committing;

	// ======================================================================
	// helpers
	function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
		page_inc = {a[AW-1:PW], a[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}};
	endfunction

	se_line_sync u_sync
	(
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.scl_i  (scl_i),
		.sda_i  (sda_i),
		.ev_o   (ev)
	);

	se_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer
	(
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.start_i (prog_start_q),
		.busy_o  (prog_busy),
		.done_o  (prog_done)
	);

	// ======================================================================
	// decode of the received byte
	wire        byte_done  = ev.rise && (bit_q == 4'h7);
	wire [7:0]  rx_byte    = {sh_q[6:0], ev.sda};
	wire        dev_match  = rx_byte[7:4] == `SE_DEV_PATTERN;
	wire        ninth_rise = ev.rise && (bit_q == 4'h8);
	wire        have_data  = |pvalid_q;
	wire [AW-1:0] rd_next  = addr_q + 11'h001;

	// ======================================================================
	// bit counter and shifter; held cleared while programming runs
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			bit_q <= 4'h0;
			sh_q  <= 8'h00;
		end
		else if (prog_busy || ev.start)
		begin
			bit_q <= 4'h0;
			sh_q  <= 8'h00;
		end
		else if (ev.rise)
		begin
			sh_q  <= rx_byte;
			bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
		end
	end

	// ======================================================================
	// protocol state machine
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			st_q         <= SE_IDLE;
			ack_q        <= 1'b0;
			rd_q         <= 1'b0;
			addr_q       <= '0;
			page_q       <= 3'h0;
			pvalid_q     <= '0;
			prow_q       <= '0;
			prog_start_q <= 1'b0;
			ackp_q       <= 1'b0;
		end
		else
		begin
			prog_start_q <= 1'b0;
			if (prog_busy)
			begin
				st_q  <= SE_IDLE;
				ack_q <= 1'b0;
				if (prog_done)
					pvalid_q <= '0;
			end
			else if (ev.stop)
			begin
				st_q  <= SE_IDLE;
				ack_q <= 1'b0;
				if (have_data)
					prog_start_q <= 1'b1;
			end
			else if (ev.start)
			begin
				st_q  <= SE_DEV;
				ack_q <= 1'b0;
			end
			else
			begin
				case (st_q)
				SE_IDLE:
					ack_q <= 1'b0;
				SE_DEV:
					if (byte_done)
					begin
						if (dev_match)
						begin
							ack_q  <= 1'b1;
							rd_q   <= rx_byte[0];
							page_q <= rx_byte[3:1];
						end
						else
							st_q <= SE_IDLE;
					end
					else if (ninth_rise)
						st_q <= rd_q ? SE_RDATA : SE_WADDR;
					else if (ev.fall && bit_q == 4'h0)
						ack_q <= 1'b0;
				SE_WADDR:
					if (byte_done)
					begin
						ack_q  <= 1'b1;
						addr_q <= {page_q, rx_byte};
						prow_q <= {page_q, rx_byte[7:PW]};
						pvalid_q <= '0;
					end
					else if (ninth_rise)
						st_q <= SE_WDATA;
					else if (ev.fall && bit_q == 4'h0)
						ack_q <= 1'b0;
				SE_WDATA:
					if (byte_done)
					begin
						ack_q <= 1'b1;
						pvalid_q[addr_q[PW-1:0]] <= 1'b1;
						addr_q <= page_inc(addr_q);
					end
					else if (ev.fall && bit_q == 4'h0)
						ack_q <= 1'b0;
				SE_RDATA:
					if (ev.rise && bit_q == 4'h7)
					begin
						st_q   <= SE_RACK;
						addr_q <= rd_next;
					end
					// drop our own ack so the read's ninth slot stays free
					else if (ev.fall)
						ack_q <= 1'b0;
				SE_RACK:
					if (ev.rise)
					begin
						ackp_q <= ~ev.sda;
						st_q   <= ev.sda ? SE_WAIT : SE_RDATA;
					end
				SE_WAIT:
					ack_q <= 1'b0;
				default:
					st_q <= SE_IDLE;
				endcase
			end
		end
	end

	// ======================================================================
	// page buffer capture; array gets nothing until programming
	always_ff @(posedge clk_i)
	begin
		if (!prog_busy && st_q == SE_WDATA && byte_done)
			pbuf_q[addr_q[PW-1:0]] <= rx_byte;
	end

	// commit one buffered byte per cycle while the timer runs
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			cmt_q <= '0;
		else if (prog_start_q)
			cmt_q <= '0;
		else if (prog_busy && cmt_q != (PW+1)'(PAGE_BYTES))
			cmt_q <= cmt_q + (PW+1)'(1);
	end

	// commit window: the first page-size cycles of the program cycle
	assign committing = prog_busy && cmt_q != (PW+1)'(PAGE_BYTES);

	always_ff @(posedge clk_i)
	begin
		if (committing && pvalid_q[cmt_q[PW-1:0]])
			mem_q[{prow_q, cmt_q[PW-1:0]}] <= pbuf_q[cmt_q[PW-1:0]];
	end

	// ======================================================================
	// read data and pin drive, updated on the falling clock edge
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			out_q   <= 8'h00;
			drive_q <= 1'b0;
		end
		else if (prog_busy || ev.stop || ev.start)
			drive_q <= 1'b0;
		else if (ev.fall)
		begin
			if (ack_q && bit_q == 4'h8)
				drive_q <= 1'b1;
			else if (st_q == SE_RDATA)
			begin
				if (bit_q == 4'h0)
				begin
					out_q   <= {mem_q[addr_q][6:0], 1'b0};
					drive_q <= ~mem_q[addr_q][7];
				end
				else
				begin
					out_q   <= {out_q[6:0], 1'b0};
					drive_q <= ~out_q[7];
				end
			end
			else
				drive_q <= 1'b0;
		end
	end

	// open drain: only the enable moves, the level is always low
	assign sda_o       = 1'b0;
	assign sda_oe_o    = drive_q;
	assign prog_busy_o = prog_busy;

	// ======================================================================
	// checks
	sequence prog_kick_s;
		prog_start_q;
	endsequence

	bus_quiet_prog_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		prog_busy |-> ##1 !drive_q)
		else $error("sda driven during programming");
	prog_follows_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		prog_kick_s |=> prog_busy)
		else $error("programming did not start after stop");
	stop_kicks_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(ev.stop && !prog_busy && have_data) |=> prog_start_q)
		else $error("stop did not trigger programming");
	mismatch_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(st_q == SE_DEV && byte_done && !dev_match && !prog_busy &&
		 !ev.stop && !ev.start) |=> st_q == SE_IDLE)
		else $error("mismatch did not return to standby");
	match_ack_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(st_q == SE_DEV && byte_done && dev_match && !prog_busy &&
		 !ev.stop && !ev.start) |=> ack_q)
		else $error("matching address not acknowledged");
	page_wrap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(st_q == SE_WDATA && byte_done && !prog_busy && !ev.stop &&
		 !ev.start) |=> addr_q[AW-1:PW] == $past(addr_q[AW-1:PW]))
		else $error("page row changed during write");
	read_inc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(st_q == SE_RDATA && ev.rise && bit_q == 4'h7 && !prog_busy &&
		 !ev.stop && !ev.start) |=> addr_q == $past(rd_next))
		else $error("read address did not advance");
	start_dev_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(ev.start && !prog_busy && !ev.stop) |=> st_q == SE_DEV)
		else $error("start did not open address phase");

	// read acknowledge slot belongs to the controller: release, then follow
	sequence ack_slot_s;
		st_q == SE_RACK && ev.fall && !prog_busy;
	endsequence

	sequence ctrl_acks_s;
		st_q == SE_RACK && ev.rise && !ev.sda && !prog_busy &&
		!ev.stop && !ev.start;
	endsequence

	read_ack_free_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ack_slot_s |=> !drive_q)
		else $error("sda driven in controller acknowledge slot");
	read_more_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ctrl_acks_s |=> (st_q == SE_RDATA && ackp_q))
		else $error("acknowledged read did not continue");
endmodule

// file: test/se_ctrl_model.sv
// bus controller model: drives the serial clock, pulls the data line low
// assumes sda_i is the resolved wire with a pull-up
`timescale 1ns/1ns
module se_ctrl_model
(
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	// ==================================================================
	// bit timing: a quarter of the 320 ns serial clock
	localparam int Q = 80;
	logic [8:0] res_q;
	event       res_e;

	// clock rests high between frames, data released
	initial
	begin
		scl_o    = 1'b1;
		sda_oe_o = 1'b0;
	end

	// data moves only in the clock low half, sampled mid high
	task automatic bit_io(input logic b, output logic s);
		#Q sda_oe_o = ~b;
		#Q scl_o = 1'b1;
		#Q s = sda_i;
		#Q scl_o = 1'b0;
	endtask

	// data falls while clock high, also as repeated start
	task automatic start();
		#Q sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b0;
	endtask

	// data rises while clock high, clock then stands still
	task automatic stop();
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b0;
		#Q;
	endtask

	// byte out msb first, then the target's answer bit
	task automatic put(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		res_q = {8'h00, s};
		->res_e;
	endtask

	// byte in; ack low releases the line to end a read
	task automatic get(input logic ack);
		logic [7:0] d;
		logic       s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ack, s);
		res_q = {1'b1, d};
		->res_e;
	endtask
endmodule

// file: test/se_eeprom_target_bench.sv
// self-checking bench of the serial eeprom target
// assumes se_ctrl_model as bus controller and a pull-up on the data line
`timescale 1ns/1ns
module se_eeprom_target_bench;
	import se_pkg::*;
	// ==================================================================
	// short programming cycle keeps the run brief; poll fits inside
	localparam int unsigned PROG = 200;
	logic       clk_i;
	logic       rstn_i;
	logic       scl;
	logic       oe_c;
	logic       oe_d;
	logic       sda_o;
	logic       busy;
	wire        sda;
	int         bad_count;
	int         n_tests;
	logic [8:0] exp_q[$];
	logic [7:0] mem[0:2047];
	logic [7:0] lfsr;

	// open-drain wire with pull-up
	assign sda = ~(oe_c | (oe_d & ~sda_o));

	initial clk_i = 1'b0;
	always #20 clk_i = ~clk_i;

	se_eeprom_target #(.PROG_CYCLES(PROG)) u_dut
	(
		.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(oe_d), .prog_busy_o(busy)
	);
	se_ctrl_model u_ctl (.sda_i(sda), .scl_o(scl), .sda_oe_o(oe_c));

	// ==================================================================
	// helpers
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic chk(input logic [8:0] e, input logic [8:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// note the expected answer bit, then send the byte
	task automatic wr(input logic [7:0] b, input logic nak);
		exp_q.push_back({8'h00, nak});
		u_ctl.put(b);
	endtask

	// note the expected data from the bench's own array copy
	task automatic rd(input logic [10:0] a, input logic more);
		exp_q.push_back({1'b1, mem[a]});
		u_ctl.get(more);
	endtask

	// start, write-direction device word, word address
	task automatic addr(input logic [10:0] a);
		u_ctl.start();
		wr({4'hA, a[10:8], 1'b0}, 1'b0);
		wr(a[7:0], 1'b0);
	endtask

	// page write: only the low four bits advance
	task automatic page(input logic [10:0] a, input int n);
		addr(a);
		for (int k = 0; k < n; k++)
		begin
			lfsr = nxt(lfsr);
			mem[{a[10:4], a[3:0] + k[3:0]}] = lfsr;
			wr(lfsr, 1'b0);
		end
		u_ctl.stop();
	endtask

	// programming runs, one poll refused, wait until busy drops, then a poll acknowledged
	task automatic settle();
		int n;
		n = 0;
		repeat (4) @(negedge clk_i);
		chk(9'h001, {8'h00, busy});
		u_ctl.start();
		wr(8'hA0, 1'b1);
		u_ctl.stop();
		while (busy !== 1'b0 && n < 400)
		begin
			@(negedge clk_i);
			n++;
		end
		chk(9'h000, {8'h00, busy});
		u_ctl.start();
		wr(8'hA0, 1'b0);
		u_ctl.stop();
	endtask

	// ==================================================================
	// result watcher: oldest note against each reported byte or answer
	initial
	forever
	begin
		@(u_ctl.res_e);
		chk(exp_q.pop_front(), u_ctl.res_q);
	end

	// watchdog: the sequence needs well under half a millisecond
	initial
	begin
		#2000000;
		bad_count++;
		end_of_test();
	end

	// ==================================================================
	// main sequence
	initial
	begin
		rstn_i    = 1'b0;
		bad_count = 0;
		n_tests   = 0;
		lfsr      = 8'h15;
		repeat (5) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		// foreign pattern is refused
		u_ctl.start();
		wr(8'h90, 1'b1);
		u_ctl.stop();
		// eighteen bytes from word 0E of page 5 wrap and overwrite
		page(11'h50E, 18);
		settle();
		// random read, then sequential over the whole page
		addr(11'h500);
		u_ctl.start();
		wr(8'hAB, 1'b0);
		for (int i = 0; i < 16; i++)
			rd(11'h500 + 11'(i), i < 15);
		u_ctl.stop();
		// last array byte, then first two bytes
		page(11'h7FF, 1);
		settle();
		page(11'h000, 2);
		settle();
		addr(11'h7FF);
		u_ctl.start();
		wr(8'hAF, 1'b0);
		rd(11'h7FF, 1'b1);
		rd(11'h000, 1'b0);
		u_ctl.stop();
		// counter kept across the stop: current address read
		u_ctl.start();
		wr(8'hA1, 1'b0);
		rd(11'h001, 1'b0);
		u_ctl.stop();
		repeat (4) @(negedge clk_i);
		end_of_test();
	end
endmodule
